/* File: vmaf_pkg.sv */
// Package for the valve mode and access state machine.
// Shared constants, mode codes, access values and port carriers.
package vmaf_pkg;

    // Access setting values
    typedef enum logic [1:0] {
        VMAF_ACC_REMOTE = 2'h0,
        VMAF_ACC_LOCAL  = 2'h1,
        VMAF_ACC_LOCKED = 2'h2
    } vmaf_access_t;

    // Control mode codes as read back and written
    localparam logic [3:0] VMAF_M_INIT     = 4'h0;
    localparam logic [3:0] VMAF_M_HOMING   = 4'h1;
    localparam logic [3:0] VMAF_M_POSITION = 4'h2;
    localparam logic [3:0] VMAF_M_CLOSE    = 4'h3;
    localparam logic [3:0] VMAF_M_OPEN     = 4'h4;
    localparam logic [3:0] VMAF_M_PRESSURE = 4'h5;
    localparam logic [3:0] VMAF_M_HOLD     = 4'h6;
    localparam logic [3:0] VMAF_M_LEARN    = 4'h7;
    localparam logic [3:0] VMAF_M_ILK_OPEN = 4'h8;
    localparam logic [3:0] VMAF_M_ILK_CLS  = 4'h9;
    localparam logic [3:0] VMAF_M_PWRFAIL  = 4'hc;
    localparam logic [3:0] VMAF_M_SAFETY   = 4'hd;
    localparam logic [3:0] VMAF_M_ERROR    = 4'he;

    // Reset values
    localparam vmaf_access_t VMAF_ACC_RESET  = VMAF_ACC_REMOTE;
    localparam logic [3:0]   VMAF_MODE_RESET = VMAF_M_INIT;

    // Display letters, ASCII
    localparam logic [7:0] VMAF_CH_I = 8'h49;
    localparam logic [7:0] VMAF_CH_H = 8'h48;
    localparam logic [7:0] VMAF_CH_C = 8'h43;
    localparam logic [7:0] VMAF_CH_O = 8'h4f;
    localparam logic [7:0] VMAF_CH_P = 8'h50;
    localparam logic [7:0] VMAF_CH_A = 8'h41;
    localparam logic [7:0] VMAF_CH_L = 8'h4c;
    localparam logic [7:0] VMAF_CH_S = 8'h53;
    localparam logic [7:0] VMAF_CH_F = 8'h46;
    localparam logic [7:0] VMAF_CH_E = 8'h45;

    // Mode request from one party
    typedef struct packed {
        logic       wr;     // One-cycle write strobe
        logic [3:0] mode;   // Requested mode code
    } vmaf_req_t;

    // Drive commands to the motion logic
    typedef struct packed {
        logic move_pos;     // Drive to target position
        logic move_prs;     // Regulate pressure
        logic drv_close;    // Drive fully shut
        logic drv_open;     // Drive fully open
        logic freeze;       // Hold present position
        logic homing;       // Run reference move
        logic learn;        // Run learn sequence
        logic motor_off;    // Motor de-energised
        logic inhibit;      // All movement inhibited
    } vmaf_drive_t;

    // Complete module state
    typedef struct packed {
        logic [3:0]   mode;       // Present control mode
        vmaf_access_t access;     // Present access setting
        logic         homed;      // Homing completed once
        logic         ilk_seen;   // An exception state is active
    } vmaf_state_t;

endpackage

/* File: vmaf_top.sv */
// Valve control-mode state machine with access arbitration.
// Assumes synchronous, debounced inputs and a motion block that reports
// homing and learn completion as one-cycle pulses.
//
// Notes on behaviour
// - Access setting is Local, Remote or Locked.
// - In Remote, service port may select Local.
// - Access setting resets to Remote.
// - In Locked, service port cannot take control.
// - In Remote, service-port mode writes are ignored.
// - Service link loss forces access to Remote.
// - Writes request a mode; reads give state.
// - Start in Init until homing or exception.
// - Homing start and end follow settings.
// - Position mode drives to target position.
// - Close shuts the valve; Open opens it.
// - Pressure mode regulates to target pressure.
// - Hold freezes; Close to Hold rejected.
// - Learn runs the characterising sequence.
// - Interlock open forces 8; release Open/Init.
// - Interlock close forces 9; release Close/Init.
// - Power failure forces 12, configured direction.
// - Safety forces 13, motor off, release Init.
// - Error inhibits motion until recovery or restart.
// - First display character shows the state.
// - Ready low for Local, exceptions, unisolated init or homing.
`timescale 1ns/1ps

module vmaf_top (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire vmaf_pkg::vmaf_req_t host_req,
    input  wire vmaf_pkg::vmaf_req_t svc_req,
    input  wire logic             svc_acc_wr,
    input  wire vmaf_pkg::vmaf_access_t svc_acc,
    input  wire logic             host_acc_wr,
    input  wire vmaf_pkg::vmaf_access_t host_acc,
    input  wire logic             svc_link_ok,
    input  wire logic             ilk_open_in,
    input  wire logic             ilk_close_in,
    input  wire logic             pwr_fail_in,
    input  wire logic             pwr_fail_opt,
    input  wire logic             pwr_fail_open,
    input  wire logic             safety_in,
    input  wire logic             error_in,
    input  wire logic             error_recover,
    input  wire logic             homing_auto,
    input  wire logic [3:0]       homing_end_mode,
    input  wire logic             homing_done,
    input  wire logic             learn_done,
    input  wire logic             has_isolation,
    input  wire logic             isolated,
    output vmaf_pkg::vmaf_access_t access,
    output logic [3:0]            mode,
    output logic [7:0]            disp_char,
    output logic                  ready,
    output vmaf_pkg::vmaf_drive_t drive
);
    import vmaf_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State and next state

    vmaf_state_t st;         // Registered state
    vmaf_state_t next_st;    // Next state
    vmaf_req_t   act_req;    // Request from the party holding rights
    logic [3:0]  req_mode;   // Mode granted this cycle

    // Check that a write target is a mode a party may request
    function automatic logic mode_ok(input logic [3:0] cur, input logic [3:0] m);
        case (m)
            VMAF_M_HOMING, VMAF_M_POSITION, VMAF_M_CLOSE, VMAF_M_OPEN,
            VMAF_M_PRESSURE, VMAF_M_LEARN: mode_ok = 1'b1;
            VMAF_M_HOLD:    mode_ok = (cur != VMAF_M_CLOSE);
            default:        mode_ok = 1'b0;   // Exceptions are not writable
        endcase
    endfunction

    // True for states only hardware may leave
    function automatic logic is_exc(input logic [3:0] m);
        is_exc = (m == VMAF_M_ILK_OPEN) || (m == VMAF_M_ILK_CLS) ||
                 (m == VMAF_M_PWRFAIL) || (m == VMAF_M_SAFETY) ||
                 (m == VMAF_M_ERROR);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Arbitration of control rights

    // Only one party's mode write is looked at
    always_comb begin
        if (st.access == VMAF_ACC_LOCAL) begin
            act_req = svc_req;
        end else begin
            act_req = host_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        next_st  = st;
        req_mode = st.mode;
        // Access setting: link loss beats all, host beats service port
        if (!svc_link_ok) begin
            next_st.access = VMAF_ACC_REMOTE;
        end else if (host_acc_wr && host_acc != 2'h3) begin
            next_st.access = host_acc;
        end else if (svc_acc_wr) begin
            if (st.access == VMAF_ACC_REMOTE && svc_acc == VMAF_ACC_LOCAL) begin
                next_st.access = VMAF_ACC_LOCAL;
            end else if (st.access == VMAF_ACC_LOCAL && svc_acc == VMAF_ACC_REMOTE) begin
                next_st.access = VMAF_ACC_REMOTE;
            end
            // Locked: service port refused, nothing changes
        end

        // Homing completion is remembered for interlock release
        if (homing_done) begin
            next_st.homed = 1'b1;
        end

        // Exceptions by priority, then releases, then normal requests
        if (st.mode == VMAF_M_ERROR && !error_recover) begin
            next_st.mode = VMAF_M_ERROR;
        end else if (error_in) begin
            next_st.mode = VMAF_M_ERROR;
        end else if (safety_in) begin
            next_st.mode = VMAF_M_SAFETY;
        end else if (pwr_fail_in && pwr_fail_opt) begin
            next_st.mode = VMAF_M_PWRFAIL;
        end else if (ilk_close_in) begin
            next_st.mode = VMAF_M_ILK_CLS;
        end else if (ilk_open_in) begin
            next_st.mode = VMAF_M_ILK_OPEN;
        end else begin
            case (st.mode)
                VMAF_M_ERROR, VMAF_M_SAFETY: begin
                    next_st.mode = VMAF_M_INIT;
                end
                VMAF_M_ILK_OPEN: begin
                    next_st.mode = st.homed ? VMAF_M_OPEN : VMAF_M_INIT;
                end
                VMAF_M_ILK_CLS: begin
                    next_st.mode = st.homed ? VMAF_M_CLOSE : VMAF_M_INIT;
                end
                VMAF_M_PWRFAIL: begin
                    next_st.mode = VMAF_M_INIT; // Power back: restart
                end
                VMAF_M_INIT: begin
                    // Stays until homing is started
                    if (act_req.wr && act_req.mode == VMAF_M_HOMING) begin
                        next_st.mode = VMAF_M_HOMING;
                    end else if (homing_auto && !st.homed) begin
                        next_st.mode = VMAF_M_HOMING;
                    end
                end
                VMAF_M_HOMING: begin
                    // End state is configured, falls back to Init if invalid
                    if (homing_done) begin
                        next_st.mode = mode_ok(VMAF_M_INIT, homing_end_mode) ?
                                       homing_end_mode : VMAF_M_INIT;
                    end
                end
                VMAF_M_LEARN: begin
                    if (learn_done) begin
                        next_st.mode = VMAF_M_POSITION;
                    end else if (act_req.wr && mode_ok(st.mode, act_req.mode)) begin
                        next_st.mode = act_req.mode;
                    end
                end
                default: begin
                    // Normal operation: granted writes only
                    if (act_req.wr && mode_ok(st.mode, act_req.mode)) begin
                        req_mode     = act_req.mode;
                        next_st.mode = req_mode;
                    end
                end
            endcase
        end
        next_st.ilk_seen = is_exc(next_st.mode);
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st.mode     <= VMAF_MODE_RESET;
            st.access   <= VMAF_ACC_RESET;
            st.homed    <= 1'b0;
            st.ilk_seen <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign mode   = st.mode;
    assign access = st.access;

    // Drive commands decoded from the state
    always_comb begin
        drive           = '0;
        drive.move_pos  = (st.mode == VMAF_M_POSITION);
        drive.move_prs  = (st.mode == VMAF_M_PRESSURE);
        drive.drv_close = (st.mode == VMAF_M_CLOSE) || (st.mode == VMAF_M_ILK_CLS) ||
                          (st.mode == VMAF_M_PWRFAIL && !pwr_fail_open);
        drive.drv_open  = (st.mode == VMAF_M_OPEN) || (st.mode == VMAF_M_ILK_OPEN) ||
                          (st.mode == VMAF_M_PWRFAIL && pwr_fail_open);
        drive.freeze    = (st.mode == VMAF_M_HOLD);
        drive.homing    = (st.mode == VMAF_M_HOMING);
        drive.learn     = (st.mode == VMAF_M_LEARN);
        drive.motor_off = (st.mode == VMAF_M_SAFETY);
        drive.inhibit   = (st.mode == VMAF_M_ERROR) || (st.mode == VMAF_M_SAFETY);
    end

    // Display letter of the present state
    always_comb begin
        case (st.mode)
            VMAF_M_INIT, VMAF_M_ILK_OPEN, VMAF_M_ILK_CLS: disp_char = VMAF_CH_I;
            VMAF_M_HOMING, VMAF_M_HOLD: disp_char = VMAF_CH_H;
            VMAF_M_CLOSE:    disp_char = VMAF_CH_C;
            VMAF_M_OPEN:     disp_char = VMAF_CH_O;
            VMAF_M_PRESSURE: disp_char = VMAF_CH_P;
            VMAF_M_POSITION: disp_char = VMAF_CH_A;
            VMAF_M_LEARN:    disp_char = VMAF_CH_L;
            VMAF_M_SAFETY:   disp_char = VMAF_CH_S;
            VMAF_M_PWRFAIL:  disp_char = VMAF_CH_F;
            default:         disp_char = VMAF_CH_E;
        endcase
    end

    // Ready for remote operation
    always_comb begin
        ready = !(st.access == VMAF_ACC_LOCAL) && !st.ilk_seen &&
                !(has_isolation && !isolated &&
                  (st.mode == VMAF_M_INIT || st.mode == VMAF_M_HOMING));
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    property p_link_loss;
        @(posedge clk) disable iff (rst)
        !svc_link_ok |=> (access == VMAF_ACC_REMOTE);
    endproperty
    a_link_loss: assert property (p_link_loss) else $error("link loss kept access");

    property p_locked_hold;
        @(posedge clk) disable iff (rst)
        (access == VMAF_ACC_LOCKED && svc_link_ok && !host_acc_wr) |=>
        (access == VMAF_ACC_LOCKED);
    endproperty
    a_locked_hold: assert property (p_locked_hold) else $error("locked access left");

    property p_svc_local;
        @(posedge clk) disable iff (rst)
        (access == VMAF_ACC_REMOTE && svc_link_ok && !host_acc_wr && svc_acc_wr &&
         svc_acc == VMAF_ACC_LOCAL) |=> (access == VMAF_ACC_LOCAL);
    endproperty
    a_svc_local: assert property (p_svc_local) else $error("local request lost");

    property p_close_hold;
        @(posedge clk) disable iff (rst)
        (mode == VMAF_M_CLOSE) |=> (mode != VMAF_M_HOLD);
    endproperty
    a_close_hold: assert property (p_close_hold) else $error("close went to hold");

    property p_remote_svc;
        @(posedge clk) disable iff (rst)
        (access != VMAF_ACC_LOCAL && mode == VMAF_M_POSITION && !host_req.wr &&
         !error_in && !safety_in && !pwr_fail_in && !ilk_open_in && !ilk_close_in)
        |=> (mode == VMAF_M_POSITION);
    endproperty
    a_remote_svc: assert property (p_remote_svc) else $error("service write obeyed");

    property p_ilk_open;
        @(posedge clk) disable iff (rst)
        (ilk_open_in && !ilk_close_in && !error_in && !safety_in && !pwr_fail_in &&
         mode != VMAF_M_ERROR) |=> (mode == VMAF_M_ILK_OPEN) && drive.drv_open;
    endproperty
    a_ilk_open: assert property (p_ilk_open) else $error("interlock open missed");

    property p_safety;
        @(posedge clk) disable iff (rst)
        (mode == VMAF_M_SAFETY && !safety_in && !error_in && !(pwr_fail_in && pwr_fail_opt) &&
         !ilk_close_in && !ilk_open_in) |=> (mode == VMAF_M_INIT);
    endproperty
    a_safety: assert property (p_safety) else $error("safety release wrong");

    property p_error_stay;
        @(posedge clk) disable iff (rst)
        (mode == VMAF_M_ERROR && !error_recover) |=> (mode == VMAF_M_ERROR) && drive.inhibit;
    endproperty
    a_error_stay: assert property (p_error_stay) else $error("error left early");

    property p_ready;
        @(posedge clk) disable iff (rst)
        (access == VMAF_ACC_LOCAL || mode == VMAF_M_ERROR) |-> !ready;
    endproperty
    a_ready: assert property (p_ready) else $error("ready high wrongly");

endmodule

/* File: vmaf_far_side.sv */
// Far-side model: the host computer and the service-tool software.
// Assumes requests are raised just after a falling clock edge and that
// idle is called on the rising edge, so strobes drop without a race.
`timescale 1ns/1ps

module vmaf_far_side (
    output vmaf_pkg::vmaf_req_t    host_req,
    output vmaf_pkg::vmaf_req_t    svc_req,
    output logic                   host_acc_wr,
    output vmaf_pkg::vmaf_access_t host_acc,
    output logic                   svc_acc_wr,
    output vmaf_pkg::vmaf_access_t svc_acc,
    output logic                   svc_link_ok
);
    import vmaf_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Drop strobes; idle mode fields flip so a stale code is never reused
    task automatic idle();
        host_req    <= {1'b0, ~host_req.mode};
        svc_req     <= {1'b0, ~svc_req.mode};
        host_acc_wr <= 1'b0;
        svc_acc_wr  <= 1'b0;
    endtask

    // Power-up: link alive, nothing requested
    initial begin
        host_req    = '0;
        svc_req     = '0;
        host_acc    = VMAF_ACC_REMOTE;
        svc_acc     = VMAF_ACC_REMOTE;
        host_acc_wr = 1'b0;
        svc_acc_wr  = 1'b0;
        svc_link_ok = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One-cycle mode writes from either party
    task automatic host_mode(input logic [3:0] m);
        host_req = {1'b1, m};
    endtask
    task automatic svc_mode(input logic [3:0] m);
        svc_req = {1'b1, m};
    endtask
    // Host may set any value, also leave Locked
    task automatic host_access(input logic [1:0] a);
        host_acc_wr = 1'b1;
        host_acc    = vmaf_access_t'(a);
    endtask
    // Tool asks for Local or gives control back
    task automatic svc_access(input logic [1:0] a);
        svc_acc_wr = 1'b1;
        svc_acc    = vmaf_access_t'(a);
    endtask
    // Cable pulled or tool closed when low
    task automatic link(input logic v);
        svc_link_ok = v;
    endtask
endmodule

/* File: valve_mode_access_fsm_tb.sv */
// Self-checking bench: integer model of mode and access compared every cycle.
// Assumes vmaf_pkg compiled first; inputs change at the falling edge.
`timescale 1ns/1ps

module valve_mode_access_fsm_tb;
    import vmaf_pkg::*;

    logic clk, rst, ilk_open_in, ilk_close_in, pwr_fail_in, pwr_fail_opt;
    logic pwr_fail_open, safety_in, error_in, error_recover, homing_auto;
    logic homing_done, learn_done, has_isolation, isolated, svc_acc_wr, host_acc_wr;
    logic svc_link_ok, ready;
    logic [3:0]   mode, homing_end_mode;
    logic [7:0]   disp_char;
    vmaf_req_t    host_req, svc_req;
    vmaf_access_t svc_acc, host_acc, access;
    vmaf_drive_t  drive;
    int err_total, check_count, m_mode, m_acc, m_homed, r;

    vmaf_far_side far (.host_req(host_req), .svc_req(svc_req), .host_acc_wr(host_acc_wr),
        .host_acc(host_acc), .svc_acc_wr(svc_acc_wr), .svc_acc(svc_acc),
        .svc_link_ok(svc_link_ok));

    vmaf_top dut (.clk(clk), .rst(rst), .host_req(host_req), .svc_req(svc_req),
        .svc_acc_wr(svc_acc_wr), .svc_acc(svc_acc), .host_acc_wr(host_acc_wr),
        .host_acc(host_acc), .svc_link_ok(svc_link_ok), .ilk_open_in(ilk_open_in),
        .ilk_close_in(ilk_close_in), .pwr_fail_in(pwr_fail_in), .pwr_fail_opt(pwr_fail_opt),
        .pwr_fail_open(pwr_fail_open), .safety_in(safety_in), .error_in(error_in),
        .error_recover(error_recover), .homing_auto(homing_auto),
        .homing_end_mode(homing_end_mode),
        .homing_done(homing_done), .learn_done(learn_done), .has_isolation(has_isolation),
        .isolated(isolated), .access(access), .mode(mode), .disp_char(disp_char),
        .ready(ready), .drive(drive));

    ////////////////////////////////////////////////////////////////////////////////
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Closing task, shared with the watchdog
    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (exp !== got) begin
            err_total++;
            $display("wrong value %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    // Letter per mode; interlocks share I, hold shares H
    function automatic logic [7:0] exp_char(input int m);
        case (m)
            0, 8, 9: return VMAF_CH_I;
            1, 6:    return VMAF_CH_H;
            2:       return VMAF_CH_A;
            3:       return VMAF_CH_C;
            4:       return VMAF_CH_O;
            5:       return VMAF_CH_P;
            7:       return VMAF_CH_L;
            12:      return VMAF_CH_F;
            13:      return VMAF_CH_S;
            default: return VMAF_CH_E;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Model step for the coming rising edge; mode uses access before update
    task automatic model_step();
        int hm;
        hm = -1;
        if (m_acc == 1 && svc_req.wr) hm = svc_req.mode;
        if (m_acc != 1 && host_req.wr) hm = host_req.mode;
        if (m_mode == 14 && !error_recover) m_mode = 14;
        else if (error_in) m_mode = 14;
        else if (safety_in) m_mode = 13;
        else if (pwr_fail_in && pwr_fail_opt) m_mode = 12;
        else if (ilk_close_in) m_mode = 9;
        else if (ilk_open_in) m_mode = 8;
        else if (m_mode == 8) m_mode = m_homed ? 4 : 0;
        else if (m_mode == 9) m_mode = m_homed ? 3 : 0;
        else if (m_mode >= 12) m_mode = 0;
        else if (m_mode == 1) begin
            // Homing ignores writes; invalid end setting falls back to Init
            if (homing_done) m_mode = (homing_end_mode inside {[1:7]}) ? homing_end_mode : 0;
        end
        else if (m_mode == 7 && learn_done) m_mode = 2;
        else if (m_mode == 0) begin
            if (hm == 1 || (homing_auto && !m_homed)) m_mode = 1;
        end
        else if (hm >= 1 && hm <= 7 && !(m_mode == 3 && hm == 6)) m_mode = hm;
        // Completion pulse marks homing done whatever the mode
        if (homing_done) m_homed = 1;
        if (!svc_link_ok) m_acc = 0;
        else if (host_acc_wr && host_acc != 2'h3) m_acc = host_acc;
        else if (svc_acc_wr && m_acc != 2 && svc_acc != 2'h2) m_acc = svc_acc;
    endtask

    // Compare every output with the model
    task automatic cmp_all();
        vmaf_drive_t d;
        int m;
        m = m_mode;
        d = {m == 2, m == 5, m == 3 || m == 9 || (m == 12 && !pwr_fail_open),
             m == 4 || m == 8 || (m == 12 && pwr_fail_open), m == 6, m == 1, m == 7,
             m == 13, m == 13 || m == 14};
        chk("mode", m_mode, mode);
        chk("access", m_acc, access);
        chk("disp_char", exp_char(m), disp_char);
        chk("ready", !(m_acc == 1 || m inside {8, 9, 12, 13, 14} || (m <= 1 && has_isolation && !isolated)), ready);
        chk("drive", d, drive);
    endtask

    // One clock: predict, drop pulses on the rising edge, compare at the falling edge
    task automatic cyc();
        model_step();
        @(posedge clk);
        far.idle();
        homing_done   <= 1'b0;
        learn_done    <= 1'b0;
        error_recover <= 1'b0;
        @(negedge clk);
        cmp_all();
    endtask

    // Six-cycle reset, outputs checked while it is held
    task automatic do_reset();
        rst = 1'b1;
        repeat (6) @(negedge clk);
        m_mode  = 0;
        m_acc   = 0;
        m_homed = 0;
        cmp_all();
        rst = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog: about 700 cycles expected, over forty times that allowed
    initial begin
        #300000;
        err_total++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        {ilk_open_in, ilk_close_in, pwr_fail_in, pwr_fail_opt, pwr_fail_open} = '0;
        {safety_in, error_in, error_recover, homing_auto, homing_done} = '0;
        {learn_done, has_isolation, isolated} = '0;
        homing_end_mode = 4'h2;
        void'($urandom(32'h5c7f));
        do_reset();
        far.host_mode(4'h2); cyc();
        homing_auto = 1'b1; cyc();
        homing_auto = 1'b0; homing_done = 1'b1; cyc();
        for (int m = 0; m < 16; m++) begin
            if (m != 1) begin
                far.host_mode(m[3:0]); cyc();
                far.host_mode(4'h2); cyc();
            end
        end
        far.host_mode(4'h3); cyc(); far.host_mode(4'h6); cyc();
        far.host_mode(4'h7); cyc(); learn_done = 1'b1; cyc();
        far.svc_mode(4'h5); cyc();
        far.svc_access(2'h1); cyc();
        far.svc_mode(4'h5); cyc(); far.host_mode(4'h4); cyc();
        far.link(1'b0); cyc(); far.link(1'b1); cyc();
        far.host_access(2'h2); cyc(); far.svc_access(2'h1); cyc();
        far.host_mode(4'h4); cyc(); far.host_access(2'h3); cyc();
        far.host_access(2'h1); cyc(); far.host_access(2'h0); cyc();
        for (int k = 0; k < 7; k++) begin
            pwr_fail_opt  = (k != 2);
            pwr_fail_open = (k == 3);
            ilk_open_in   = (k == 0);
            ilk_close_in  = (k == 1);
            pwr_fail_in   = (k inside {2, 3, 4});
            safety_in     = (k == 5);
            error_in      = (k == 6);
            repeat (2) begin far.host_mode(4'h5); cyc(); end
            {ilk_open_in, ilk_close_in, pwr_fail_in, safety_in, error_in} = '0;
            cyc();
            error_recover = (k == 6); cyc();
            far.host_mode(4'h5); cyc();
        end
        do_reset();
        has_isolation = 1'b1;
        ilk_close_in = 1'b1; cyc(); ilk_close_in = 1'b0; cyc();
        for (int i = 0; i < 600; i++) begin
            r = $urandom_range(0, 7);
            far.link(r != 5);
            has_isolation = 1'($urandom);
            isolated = 1'($urandom);
            homing_auto = 1'($urandom);
            homing_end_mode = 4'($urandom);
            pwr_fail_opt = 1'($urandom);
            pwr_fail_open = 1'($urandom);
            // Rare exception bursts, one cycle long, so releases are exercised too
            {ilk_open_in, ilk_close_in, pwr_fail_in, safety_in, error_in} =
                ($urandom_range(0, 11) == 0) ? 5'($urandom) : 5'h0;
            if (m_mode == 1) homing_done = 1'b1;
            else case (r)
                0: far.host_mode(4'($urandom_range(0, 15)));
                1: far.svc_mode(4'($urandom_range(0, 15)));
                2: far.host_access(2'($urandom_range(0, 3)));
                3: far.svc_access(2'($urandom_range(0, 1)));
                4: learn_done = (m_mode == 7);
                5: error_recover = 1'b1;
                default: ;
            endcase
            cyc();
        end
        report_and_stop();
    end
endmodule
